// File: pkg/ramp_cal_cfg.svh
// constants for the ramp calibration register slice
// Contract
// - calibrate at each ramp start while idle, when enabled and ramp mode is automatic
// - scale exponent resets seven, sets cal time
// - state clock is reference over two-power divider
// - four spare registers read zero
// - lock codes 0,1 unlocked, 2 locked, 3 invalid
// - selected core field reports cores one-six
// - capacitor code in low byte
// - dac current code in low nine bits
// - ramp mode bit clear means automatic
`ifndef RAMP_CAL_CFG_SVH
`define RAMP_CAL_CFG_SVH
`define OFS_RAMP_CAL_CONFIG 8'h6A
`define OFS_SPARE_READ_A 8'h6B
`define OFS_SPARE_READ_B 8'h6C
`define OFS_SPARE_READ_C 8'h6D
`define OFS_LOCK_CORE_STATUS 8'h6E
`define OFS_CAL_CAP_STATUS 8'h6F
`define OFS_CAL_DAC_STATUS 8'h70
`define OFS_SPARE_READ_D 8'h71
`define OFS_KEYING_CONTROL 8'h72
`define OFS_RAMP_CTRL 8'h80
`define OFS_IRQ_STATUS 8'h84
`define OFS_IRQ_MASK 8'h88
`define RST_RAMP_CAL_CONFIG 16'h0007
`define RST_KEYING_CONTROL 16'h7800
`define RST_RAMP_CTRL 16'h4440
`define BIT_CAL_ON_RAMP 4
`define BIT_RAMP_MANUAL 5
`define FLD_SCALE_HI 2
`define FLD_DLY_HI 15
`define FLD_DLY_LO 6
`define MASK_RAMP_CAL_CONFIG 16'h0017
`define LOCK_CODE_LOCKED 2'h2
`define LOCK_CODE_INVALID 2'h3
`define IRQ_BITS 3
`endif

// File: pkg/ramp_cal_pkg.sv
// types for the ramp calibration register slice
package ramp_cal_pkg;
	typedef enum logic [2:0] {
		CAL_IDLE = 3'b001,
		CAL_RUN = 3'b010,
		CAL_DONE = 3'b100
	} cal_state_t;
	typedef logic [15:0] reg16_t;
endpackage

// File: pkg/cal_ctrl_if.sv
// control and result signals between register bank and sequencer
`timescale 1ns/1ps
interface cal_ctrl_if;
	logic cal_on_each_ramp_en;
	logic ramp_manual;
	logic [2:0] scale_exp;
	logic [9:0] ramp_cal_delay_count;
	logic [2:0] clk_div;
	logic cal_start;
	logic cal_busy;
	logic cal_done;
	modport bank (output cal_on_each_ramp_en, ramp_manual, scale_exp,
		ramp_cal_delay_count, clk_div, input cal_start, cal_busy, cal_done);
	modport seq (input cal_on_each_ramp_en, ramp_manual, scale_exp,
		ramp_cal_delay_count, clk_div, output cal_start, cal_busy, cal_done);
endinterface

// File: design/smc_divider.sv
// state machine clock enable divider
`timescale 1ns/1ps
module smc_divider
	import ramp_cal_pkg::*;
#(
	parameter int DIV_W = 8
)(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [2:0] div_exp,
	output logic tick
);
	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] lim;
	always_comb
	begin
		lim = DIV_W'((1 << div_exp) - 1);
	end
	// f_smc = f_ref / 2^div
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= '0;
			tick <= 1'b0;
		end
		else if (cnt_q >= lim)
		begin
			cnt_q <= '0;
			tick <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule

// File: design/cal_sequencer.sv
// ramp-start calibration sequencer
`timescale 1ns/1ps
module cal_sequencer
	import ramp_cal_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ramp_start,
	input wire logic smc_tick,
	cal_ctrl_if.seq ctl
);
	cal_state_t state_q;
	logic [19:0] cnt_q;
	logic [19:0] len;
	always_comb
	begin
		// delay count scaled by two to the exponent
		len = 20'(ctl.ramp_cal_delay_count) << ctl.scale_exp;
	end
	assign ctl.cal_start = (state_q == CAL_IDLE) && ramp_start &&
		ctl.cal_on_each_ramp_en && !ctl.ramp_manual;
	assign ctl.cal_busy = (state_q == CAL_RUN);
	assign ctl.cal_done = (state_q == CAL_DONE);
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= CAL_IDLE;
			cnt_q <= '0;
		end
		else
		begin
			case (state_q)
				CAL_IDLE:
				begin
					cnt_q <= '0;
					if (ctl.cal_start)
						state_q <= CAL_RUN;
				end
				CAL_RUN:
				begin
					if (smc_tick)
						cnt_q <= cnt_q + 20'h00001;
					if (smc_tick && cnt_q + 20'h00001 >= len)
						state_q <= CAL_DONE;
				end
				CAL_DONE:
					state_q <= CAL_IDLE;
				default:
					state_q <= CAL_IDLE;
			endcase
		end
	end
endmodule

// File: design/ramp_cal_readback_regs.sv
// register bank for ramp calibration control and readback
`timescale 1ns/1ps
`include "ramp_cal_cfg.svh"
module ramp_cal_readback_regs
	import ramp_cal_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic RAMP_START,
	input wire logic [1:0] TUNE_VOLTAGE_LOCK_STATE,
	input wire logic [2:0] CHOSEN_OSC_CORE,
	input wire logic [7:0] CHOSEN_CAP_BANK_CODE,
	input wire logic [8:0] CHOSEN_DAC_CURRENT_CODE,
	output logic CAL_BUSY,
	output logic CAL_START_PULSE,
	output logic IRQ
);
	cal_ctrl_if ctl ();
	logic smc_tick;
	reg16_t ramp_cal_config_q;
	reg16_t keying_control_q;
	reg16_t ramp_ctrl_q;
	reg16_t lock_core_q;
	reg16_t cap_q;
	reg16_t dac_q;
	logic [`IRQ_BITS-1:0] irq_status_q;
	logic [`IRQ_BITS-1:0] irq_mask_q;
	logic [`IRQ_BITS-1:0] ev;
	logic [1:0] lock_prev_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [7:0] a_addr;
	logic a_valid;
	logic [31:0] rd_d;
	logic rd_en;
	logic hit_cfg;
	logic hit_lock;
	logic hit_cap;
	logic hit_dac;
	logic hit_key;
	logic hit_ctrl;
	logic hit_ists;
	logic hit_imsk;
	logic hit_spare;
	logic we_cfg;
	logic we_key;
	logic we_ctrl;
	logic we_mask;
	logic we_clr;

	assign a_valid = HSEL && HREADY && HTRANS[1];
	assign a_addr = HADDR[9:2];

	// read request seen in the address phase
	assign rd_en = a_valid && !HWRITE;

	// address phase decode
	assign hit_cfg = (a_addr == `OFS_RAMP_CAL_CONFIG);
	assign hit_lock = (a_addr == `OFS_LOCK_CORE_STATUS);
	assign hit_cap = (a_addr == `OFS_CAL_CAP_STATUS);
	assign hit_dac = (a_addr == `OFS_CAL_DAC_STATUS);
	assign hit_key = (a_addr == `OFS_KEYING_CONTROL);
	assign hit_ctrl = (a_addr == `OFS_RAMP_CTRL);
	assign hit_ists = (a_addr == `OFS_IRQ_STATUS);
	assign hit_imsk = (a_addr == `OFS_IRQ_MASK);
	// spare words, always zero
	assign hit_spare = (a_addr == `OFS_SPARE_READ_A) ||
		(a_addr == `OFS_SPARE_READ_B) ||
		(a_addr == `OFS_SPARE_READ_C) ||
		(a_addr == `OFS_SPARE_READ_D);

	// write strobes, one per writable register
	assign we_cfg = wr_pend_q && (wr_addr_q == `OFS_RAMP_CAL_CONFIG);
	assign we_key = wr_pend_q && (wr_addr_q == `OFS_KEYING_CONTROL);
	assign we_ctrl = wr_pend_q && (wr_addr_q == `OFS_RAMP_CTRL);
	assign we_mask = wr_pend_q && (wr_addr_q == `OFS_IRQ_MASK);
	assign we_clr = wr_pend_q && (wr_addr_q == `OFS_IRQ_STATUS);

	assign ctl.cal_on_each_ramp_en = ramp_cal_config_q[`BIT_CAL_ON_RAMP];
	assign ctl.scale_exp = ramp_cal_config_q[`FLD_SCALE_HI:0];
	assign ctl.ramp_manual = ramp_ctrl_q[`BIT_RAMP_MANUAL];
	assign ctl.ramp_cal_delay_count = ramp_ctrl_q[`FLD_DLY_HI:`FLD_DLY_LO];
	assign ctl.clk_div = ramp_ctrl_q[2:0];

	smc_divider #(.DIV_W(8)) u_div (
		.clk(SYS_CLK),
		.arst_n(ARST_N),
		.div_exp(ctl.clk_div),
		.tick(smc_tick)
	);

	cal_sequencer u_seq (
		.clk(SYS_CLK),
		.arst_n(ARST_N),
		.ramp_start(RAMP_START),
		.smc_tick(smc_tick),
		.ctl(ctl)
	);

	// write pending flag, data follows in next cycle
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			wr_pend_q <= 1'b0;
		else
			wr_pend_q <= a_valid && HWRITE;
	end

	// write address held for the data phase
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			wr_addr_q <= 8'h00;
		else
			wr_addr_q <= a_addr;
	end

	// calibration config, unused bits forced zero
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			ramp_cal_config_q <= `RST_RAMP_CAL_CONFIG;
		else if (we_cfg)
			ramp_cal_config_q <= HWDATA[15:0] & `MASK_RAMP_CAL_CONFIG;
	end

	// keying control, plain storage
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			keying_control_q <= `RST_KEYING_CONTROL;
		else if (we_key)
			keying_control_q <= HWDATA[15:0];
	end

	// ramp control: delay count, mode, divider
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			ramp_ctrl_q <= `RST_RAMP_CTRL;
		else if (we_ctrl)
			ramp_ctrl_q <= HWDATA[15:0];
	end

	// interrupt mask
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			irq_mask_q <= '0;
		else if (we_mask)
			irq_mask_q <= HWDATA[`IRQ_BITS-1:0];
	end

	// lock and core readback, undefined bits zero
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			lock_core_q <= 16'h0000;
		else
			lock_core_q <= {5'h00, TUNE_VOLTAGE_LOCK_STATE, 1'b0,
				CHOSEN_OSC_CORE, 5'h00};
	end

	// capacitor code readback
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			cap_q <= 16'h0000;
		else
			cap_q <= {8'h00, CHOSEN_CAP_BANK_CODE};
	end

	// dac current code readback
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			dac_q <= 16'h0000;
		else
			dac_q <= {7'h00, CHOSEN_DAC_CURRENT_CODE};
	end

	// previous lock code for edge events
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			lock_prev_q <= 2'h0;
		else
			lock_prev_q <= lock_core_q[10:9];
	end

	// events: cal done, lock gained, invalid lock code
	assign ev[0] = ctl.cal_done;
	assign ev[1] = (lock_core_q[10:9] == `LOCK_CODE_LOCKED) &&
		(lock_prev_q != `LOCK_CODE_LOCKED);
	assign ev[2] = (lock_core_q[10:9] == `LOCK_CODE_INVALID) &&
		(lock_prev_q != `LOCK_CODE_INVALID);

	// sticky status per bit, write one to clear, set wins
	genvar gi;
	generate
		for (gi = 0; gi < `IRQ_BITS; gi++)
		begin : g_irq
			always_ff @(posedge SYS_CLK or negedge ARST_N)
			begin
				if (!ARST_N)
					irq_status_q[gi] <= 1'b0;
				else if (ev[gi])
					irq_status_q[gi] <= 1'b1;
				else if (we_clr && HWDATA[gi])
					irq_status_q[gi] <= 1'b0;
			end
		end
	endgenerate

	// read mux, spares and unmapped read zero
	always_comb
	begin
		rd_d = 32'h00000000;
		if (hit_cfg)
			rd_d = {16'h0000, ramp_cal_config_q};
		else if (hit_lock)
			rd_d = {16'h0000, lock_core_q};
		else if (hit_cap)
			rd_d = {16'h0000, cap_q};
		else if (hit_dac)
			rd_d = {16'h0000, dac_q};
		else if (hit_key)
			rd_d = {16'h0000, keying_control_q};
		else if (hit_ctrl)
			rd_d = {16'h0000, ramp_ctrl_q};
		else if (hit_ists)
			rd_d = {29'h00000000, irq_status_q};
		else if (hit_imsk)
			rd_d = {29'h00000000, irq_mask_q};
		else if (hit_spare)
			rd_d = 32'h00000000;
		else
			rd_d = 32'h00000000;
	end

	// read data registered in the address phase
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			HRDATA <= 32'h00000000;
		else if (rd_en)
			HRDATA <= rd_d;
	end

	// no wait states, response always okay
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
		else
		begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// calibration busy flag
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			CAL_BUSY <= 1'b0;
		else
			CAL_BUSY <= ctl.cal_busy;
	end

	// calibration start pulse
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			CAL_START_PULSE <= 1'b0;
		else
			CAL_START_PULSE <= ctl.cal_start;
	end

	// level interrupt from unmasked status
	always_ff @(posedge SYS_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			IRQ <= 1'b0;
		else
			IRQ <= |(irq_status_q & irq_mask_q);
	end
endmodule

// File: bench/ramp_cal_asserts.sv
// port assertions for the ramp calibration register slice
`timescale 1ns/1ps
module ramp_cal_asserts (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic RAMP_START,
	input wire logic CAL_BUSY,
	input wire logic CAL_START_PULSE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	wire rd = HSEL & HREADY & HTRANS[1] & !HWRITE;
	wire [7:0] ix = HADDR[9:2];
	a_spare_zero: assert property (rd && ix inside {8'h6B, 8'h6C, 8'h6D,
		8'h71} |=> HRDATA == 32'h0) else $error("spare not zero");
	a_config_unused: assert property (rd && ix == 8'h6A |=>
		(HRDATA & ~32'h17) == 32'h0) else $error("config spare bits set");
	a_status_bits: assert property (rd && ix == 8'h6E |=>
		(HRDATA & ~32'h6E0) == 32'h0) else $error("status spare bits set");
	a_cap_width: assert property (rd && ix == 8'h6F |=>
		HRDATA[31:8] == 24'h0) else $error("cap code too wide");
	a_dac_width: assert property (rd && ix == 8'h70 |=>
		HRDATA[31:9] == 23'h0) else $error("dac code too wide");
	a_start_cause: assert property (CAL_START_PULSE |->
		$past(RAMP_START)) else $error("start without ramp");
	a_start_single: assert property (CAL_START_PULSE |=>
		!CAL_START_PULSE) else $error("start pulse too long");
	a_start_busy: assert property (CAL_START_PULSE |->
		##[0:2] CAL_BUSY) else $error("start without busy");
endmodule

// File: bench/test_ramp_cal_readback_regs.sv
// self-checking bench for the ramp calibration register slice
`timescale 1ns/1ps
`include "ramp_cal_cfg.svh"
module test_ramp_cal_readback_regs;
	logic SYS_CLK = 0, ARST_N = 0, HSEL = 0, HWRITE = 0, RAMP_START = 0;
	logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
	logic [1:0] HTRANS = 0, TUNE_VOLTAGE_LOCK_STATE = 0;
	logic [2:0] HSIZE = 3'h2, CHOSEN_OSC_CORE = 0;
	logic [7:0] CHOSEN_CAP_BANK_CODE = 0;
	logic [8:0] CHOSEN_DAC_CURRENT_CODE = 0;
	logic HREADYOUT, HRESP, CAL_BUSY, CAL_START_PULSE, IRQ;
	int err_count = 0, tests_run = 0, cyc = 0;
	always #50 SYS_CLK = ~SYS_CLK;
	ramp_cal_readback_regs dut (
		.SYS_CLK(SYS_CLK),
		.ARST_N(ARST_N),
		.HSEL(HSEL),
		.HADDR(HADDR),
		.HTRANS(HTRANS),
		.HWRITE(HWRITE),
		.HSIZE(HSIZE),
		.HWDATA(HWDATA),
		.HREADY(HREADYOUT),
		.HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT),
		.HRESP(HRESP),
		.RAMP_START(RAMP_START),
		.TUNE_VOLTAGE_LOCK_STATE(TUNE_VOLTAGE_LOCK_STATE),
		.CHOSEN_OSC_CORE(CHOSEN_OSC_CORE),
		.CHOSEN_CAP_BANK_CODE(CHOSEN_CAP_BANK_CODE),
		.CHOSEN_DAC_CURRENT_CODE(CHOSEN_DAC_CURRENT_CODE),
		.CAL_BUSY(CAL_BUSY),
		.CAL_START_PULSE(CAL_START_PULSE),
		.IRQ(IRQ)
	);
	task conclude;
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge SYS_CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_count++;
			$display("mismatch at %0t: timeout", $time);
			conclude;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task xfer(input logic w, input logic [7:0] i, input logic [31:0] wd,
		output logic [31:0] rdat);
		HSEL <= 1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {22'h0, i, 2'h0};
		do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
		rdat = HRDATA;
	endtask
	task wr(input logic [7:0] i, input logic [31:0] v);
		logic [31:0] x;
		xfer(1'b1, i, v, x);
	endtask
	task rc(input logic [7:0] i, input logic [31:0] e);
		logic [31:0] x;
		xfer(1'b0, i, 32'h0, x);
		chk(x, e);
		chk({31'h0, HRESP}, 32'h0);
	endtask
	task t_reset;
		rc(`OFS_RAMP_CAL_CONFIG, 32'h7);
		rc(`OFS_RAMP_CTRL, 32'h4440);
		rc(`OFS_KEYING_CONTROL, 32'h7800);
		for (int i = 8'h6B; i < 8'h72; i++) rc(8'(i), 32'h0);
	endtask
	task t_write;
		wr(`OFS_RAMP_CAL_CONFIG, 32'h00000017);
		rc(`OFS_RAMP_CAL_CONFIG, 32'h17);
		for (int i = 8'h6B; i < 8'h72; i++) wr(8'(i), 32'hFFFF);
		for (int i = 8'h6B; i < 8'h72; i++) rc(8'(i), 32'h0);
		wr(8'h10, 32'hFFFF);
		rc(8'h10, 32'h0);
		wr(`OFS_KEYING_CONTROL, 32'h1234);
		rc(`OFS_KEYING_CONTROL, 32'h1234);
	endtask
	task t_status;
		for (int k = 0; k < 4; k++)
		begin
			TUNE_VOLTAGE_LOCK_STATE <= 2'(k);
			CHOSEN_OSC_CORE <= 3'(k + 3);
			CHOSEN_CAP_BANK_CODE <= 8'(8'hA5 ^ k);
			CHOSEN_DAC_CURRENT_CODE <= 9'(9'h1C3 + k);
			repeat (2) @(posedge SYS_CLK);
			rc(8'h6E, (k << 9) | ((k + 3) << 5));
			rc(8'h6F, 32'hA5 ^ k);
			rc(8'h70, 32'h1C3 + k);
		end
		rc(`OFS_IRQ_STATUS, 32'h6);
		TUNE_VOLTAGE_LOCK_STATE <= 2'h0;
		wr(`OFS_IRQ_STATUS, 32'h7);
		rc(`OFS_IRQ_STATUS, 32'h0);
		chk({31'h0, IRQ}, 32'h0);
	endtask
	task cal_run(input logic [31:0] cfg, input logic [31:0] ctl,
		input int lo, input int hi);
		int n, np;
		wr(`OFS_RAMP_CTRL, ctl);
		wr(`OFS_RAMP_CAL_CONFIG, cfg);
		n = 0;
		np = 0;
		RAMP_START <= 1;
		@(posedge SYS_CLK);
		RAMP_START <= 0;
		repeat (50)
		begin
			@(negedge SYS_CLK);
			if (CAL_BUSY === 1'b1) n++;
			if (CAL_START_PULSE === 1'b1) np++;
		end
		@(posedge SYS_CLK);
		chk(np, (lo > 0) ? 1 : 0);
		chk({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask
	task t_cal;
		wr(`OFS_IRQ_MASK, 32'h1);
		cal_run(32'h11, 32'h81, 7, 8);
		chk({31'h0, IRQ}, 32'h1);
		wr(`OFS_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge SYS_CLK);
		chk({31'h0, IRQ}, 32'h0);
		cal_run(32'h12, 32'h81, 15, 16);
		cal_run(32'h12, 32'h82, 29, 32);
		cal_run(32'h02, 32'h81, 0, 0);
		cal_run(32'h12, 32'hA1, 0, 0);
	endtask
	initial
	begin
		repeat (2) @(posedge SYS_CLK);
		ARST_N <= 1;
		t_reset;
		t_write;
		t_status;
		t_cal;
		conclude;
	end
endmodule
bind ramp_cal_readback_regs ramp_cal_asserts chk_i (
	.SYS_CLK(SYS_CLK),
	.ARST_N(ARST_N),
	.HSEL(HSEL),
	.HADDR(HADDR),
	.HTRANS(HTRANS),
	.HWRITE(HWRITE),
	.HREADY(HREADY),
	.HRDATA(HRDATA),
	.RAMP_START(RAMP_START),
	.CAL_BUSY(CAL_BUSY),
	.CAL_START_PULSE(CAL_START_PULSE)
);
